// file: src/sgs_ctrl.sv
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
module sgs_ctrl #(
    parameter int TICK_CYCLES = sgs_pkg::SGS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic irq,
    // Setting group control
    input wire logic [4:0] group_activate,
    input wire logic group_change_block,
    output logic [2:0] active_group,
    // Selector control inputs
    input wire logic step_advance,
    input wire logic step_ack,
    input wire logic position_code_bit0,
    input wire logic position_code_bit1,
    input wire logic position_code_bit2,
    input wire logic code_ack,
    // Selector outputs
    output logic [2:0] selector_position,
    output logic step_alarm,
    output logic code_alarm,
    output logic range_alarm,
    output logic power_alarm,
    // Non-volatile position store
    input wire logic [2:0] nv_position_in,
    output logic [2:0] nv_position_out,
    output logic nv_write
);
    import sgs_pkg::*;

    // ****************************************************************
    // Register bus slave
    // ****************************************************************
    logic ack_reg;
    logic [31:0] readdata_reg;
    logic [5:0] cfg_reg;
    logic [15:0] timeout_reg;
    logic [SGS_IRQ_BITS-1:0] irq_stat_reg;
    logic [SGS_IRQ_BITS-1:0] irq_mask_reg;
    logic [SGS_IRQ_BITS-1:0] irq_event;
    logic wr_en;
    logic [31:0] status_word;
    logic [2:0] full_range;
    logic step_ack_mode;
    logic code_ack_mode;
    logic pwr_sync_mode;

    // Each access is answered on its second cycle.
    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_en = write & ack_reg;
    assign readdata = readdata_reg;

    assign full_range = cfg_reg[SGS_CFG_RANGE_LSB +: 3];
    assign step_ack_mode = cfg_reg[SGS_CFG_STEP_ACK_BIT];
    assign code_ack_mode = cfg_reg[SGS_CFG_CODE_ACK_BIT];
    assign pwr_sync_mode = cfg_reg[SGS_CFG_PWR_SYNC_BIT];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            readdata_reg <= 32'h0;
        end
        else if (read && !ack_reg)
        begin
            unique case (address)
                SGS_CFG_OFS: readdata_reg <= {26'h0, cfg_reg};
                SGS_TIMEOUT_OFS: readdata_reg <= {16'h0, timeout_reg};
                SGS_STATUS_OFS: readdata_reg <= status_word;
                SGS_IRQ_STAT_OFS: readdata_reg <= {26'h0, irq_stat_reg};
                SGS_IRQ_MASK_OFS: readdata_reg <= {26'h0, irq_mask_reg};
                default: readdata_reg <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cfg_reg <= SGS_CFG_RESET;
            timeout_reg <= SGS_TIMEOUT_RESET;
            irq_mask_reg <= '0;
        end
        else if (wr_en)
        begin
            if (address == SGS_CFG_OFS)
            begin
                cfg_reg <= writedata[5:0];
            end
            if (address == SGS_TIMEOUT_OFS)
            begin
                timeout_reg <= writedata[15:0];
            end
            if (address == SGS_IRQ_MASK_OFS)
            begin
                irq_mask_reg <= writedata[SGS_IRQ_BITS-1:0];
            end
        end
    end

    // ****************************************************************
    // Interrupt status
    // ****************************************************************
    // A new event in the clearing cycle keeps its bit set.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            irq_stat_reg <= '0;
        end
        else
        begin
            if (wr_en && address == SGS_IRQ_STAT_OFS)
            begin
                irq_stat_reg <= (irq_stat_reg & ~writedata[SGS_IRQ_BITS-1:0]) | irq_event;
            end
            else
            begin
                irq_stat_reg <= irq_stat_reg | irq_event;
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ****************************************************************
    // Setting group selection
    // ****************************************************************
    sgs_grp_if grp_bus ();

    assign grp_bus.req = group_activate;
    assign grp_bus.block = group_change_block;
    assign active_group = grp_bus.active;

    sgs_group_sel u_group_sel (
        .core_clk(core_clk),
        .rst(rst),
        .grp(grp_bus.ctl)
    );

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    logic [15:0] tick_cnt_reg;
    logic ms_tick;

    assign ms_tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

    always_ff @(posedge core_clk)
    begin
        if (rst || ms_tick)
        begin
            tick_cnt_reg <= 16'h0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 16'h1;
        end
    end

    // ****************************************************************
    // Selector input edges and code checks
    // ****************************************************************
    logic [2:0] code_in;
    logic [2:0] code_prev_reg;
    logic step_prev_reg;
    logic step_ack_prev_reg;
    logic code_ack_prev_reg;
    logic step_rise;
    logic step_ack_rise;
    logic code_ack_rise;
    logic code_change;
    logic code_valid;
    logic code_rest;

    assign code_in = {position_code_bit2, position_code_bit1, position_code_bit0};
    assign step_rise = step_advance & ~step_prev_reg;
    assign step_ack_rise = step_ack & ~step_ack_prev_reg;
    assign code_ack_rise = code_ack & ~code_ack_prev_reg;
    assign code_change = code_in != code_prev_reg;
    assign code_rest = code_in == SGS_POS_NONE;
    assign code_valid = !code_rest && code_in <= full_range;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            step_prev_reg <= 1'b0;
            step_ack_prev_reg <= 1'b0;
            code_ack_prev_reg <= 1'b0;
            code_prev_reg <= SGS_POS_NONE;
        end
        else
        begin
            step_prev_reg <= step_advance;
            step_ack_prev_reg <= step_ack;
            code_ack_prev_reg <= code_ack;
            code_prev_reg <= code_in;
        end
    end

    // ****************************************************************
    // Selector sequence
    // ****************************************************************
    sgs_sel_state_t sel_state_reg;
    logic [2:0] pos_reg;
    logic [2:0] pre_reg;
    logic [15:0] wait_reg;
    logic wait_done;
    logic pu_done_reg;
    logic apply;
    logic discard;
    logic [SGS_ALARMS-1:0] alarm_start;
    logic [SGS_ALARMS-1:0] alarm_active;
    logic [2:0] step_next;
    logic [2:0] pu_pos;
    logic pu_ok;
    logic seq_ack_mode;
    logic seq_ack_rise;

    // Wraps at the upper position; an unset position steps to one.
    assign step_next = (pre_reg >= full_range) ? SGS_POS_FIRST : pre_reg + 3'h1;
    assign seq_ack_mode = (sel_state_reg == SGS_SEL_STEP) ? step_ack_mode : code_ack_mode;
    assign seq_ack_rise = (sel_state_reg == SGS_SEL_STEP) ? step_ack_rise : code_ack_rise;
    assign wait_done = wait_reg == 16'h0;
    assign apply = pu_done_reg && sel_state_reg != SGS_SEL_IDLE
        && (seq_ack_mode ? seq_ack_rise : wait_done);
    assign discard = pu_done_reg && sel_state_reg != SGS_SEL_IDLE
        && seq_ack_mode && !seq_ack_rise && wait_done;
    assign pu_pos = pwr_sync_mode ? code_in : nv_position_in;
    assign pu_ok = pu_pos != SGS_POS_NONE && pu_pos <= full_range;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            sel_state_reg <= SGS_SEL_IDLE;
            pre_reg <= SGS_POS_NONE;
        end
        else if (!pu_done_reg || apply || discard)
        begin
            sel_state_reg <= SGS_SEL_IDLE;
            pre_reg <= !pu_done_reg ? (pu_ok ? pu_pos : SGS_POS_NONE)
                : (apply ? pre_reg : pos_reg);
        end
        else
        begin
            unique case (sel_state_reg)
                SGS_SEL_IDLE:
                begin
                    if (step_rise)
                    begin
                        sel_state_reg <= SGS_SEL_STEP;
                        pre_reg <= step_next;
                    end
                    else if (code_change && code_valid)
                    begin
                        sel_state_reg <= SGS_SEL_CODE;
                        pre_reg <= code_in;
                    end
                end
                SGS_SEL_STEP:
                begin
                    if (step_rise)
                    begin
                        pre_reg <= step_next;
                    end
                end
                SGS_SEL_CODE:
                begin
                    if (code_change && code_valid)
                    begin
                        pre_reg <= code_in;
                    end
                end
            endcase
        end
    end

    // Time-out restarts on each activity of the sequence's own input.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wait_reg <= 16'h0;
        end
        else if ((sel_state_reg != SGS_SEL_CODE && step_rise)
            || (sel_state_reg != SGS_SEL_STEP && code_change && code_valid))
        begin
            wait_reg <= timeout_reg;
        end
        else if (ms_tick && !wait_done)
        begin
            wait_reg <= wait_reg - 16'h1;
        end
    end

    // Applied position, with power-up load and storage write.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pu_done_reg <= 1'b0;
            pos_reg <= SGS_POS_NONE;
            nv_position_out <= SGS_POS_NONE;
            nv_write <= 1'b0;
        end
        else
        begin
            nv_write <= 1'b0;
            if (!pu_done_reg)
            begin
                pu_done_reg <= 1'b1;
                pos_reg <= pu_ok ? pu_pos : SGS_POS_NONE;
            end
            else if (apply)
            begin
                pos_reg <= pre_reg;
                nv_position_out <= pre_reg;
                nv_write <= 1'b1;
            end
        end
    end

    assign selector_position = pos_reg;

    // ****************************************************************
    // Timed alarms
    // ****************************************************************
    assign alarm_start[SGS_AL_STEP] = discard && sel_state_reg == SGS_SEL_STEP;
    assign alarm_start[SGS_AL_CODE] = discard && sel_state_reg == SGS_SEL_CODE;
    assign alarm_start[SGS_AL_RANGE] = pu_done_reg && sel_state_reg != SGS_SEL_STEP
        && code_change && !code_rest && !code_valid;
    assign alarm_start[SGS_AL_PWR] = !pu_done_reg && !pu_ok;

    generate
        for (genvar a = 0; a < SGS_ALARMS; a++)
        begin : g_alarm
            logic [11:0] left_reg;

            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    left_reg <= 12'h0;
                end
                else if (alarm_start[a])
                begin
                    left_reg <= SGS_ALARM_TICKS;
                end
                else if (ms_tick && left_reg != 12'h0)
                begin
                    left_reg <= left_reg - 12'h1;
                end
            end

            assign alarm_active[a] = left_reg != 12'h0;
        end
    endgenerate

    assign step_alarm = alarm_active[SGS_AL_STEP];
    assign code_alarm = alarm_active[SGS_AL_CODE];
    assign range_alarm = alarm_active[SGS_AL_RANGE];
    assign power_alarm = alarm_active[SGS_AL_PWR];

    assign irq_event = {grp_bus.changed, alarm_start, apply};

    assign status_word = {18'h0, alarm_active,
        sel_state_reg != SGS_SEL_IDLE,
        grp_bus.active, pre_reg, pos_reg};
endmodule : sgs_ctrl

// file: src/sgs_pkg.sv
package sgs_pkg;
    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int SGS_CLK_PERIOD_NS = 20;
    localparam int SGS_TICK_PERIOD_NS = 1000000;
    localparam int SGS_TICK_CYCLES = SGS_TICK_PERIOD_NS / SGS_CLK_PERIOD_NS;
    localparam int SGS_ALARM_TIME_S = 3;
    localparam logic [11:0] SGS_ALARM_TICKS = 12'(SGS_ALARM_TIME_S * 1000);
    localparam int SGS_ALARMS = 4;

    // ****************************************************************
    // Setting groups and selector positions
    // ****************************************************************
    localparam int SGS_GROUPS = 6;
    localparam logic [2:0] SGS_GROUP_DEFAULT = 3'h1;
    localparam logic [2:0] SGS_POS_NONE = 3'h0;
    localparam logic [2:0] SGS_POS_FIRST = 3'h1;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [4:0] SGS_CFG_OFS = 5'h00;
    localparam logic [4:0] SGS_TIMEOUT_OFS = 5'h04;
    localparam logic [4:0] SGS_STATUS_OFS = 5'h08;
    localparam logic [4:0] SGS_IRQ_STAT_OFS = 5'h0c;
    localparam logic [4:0] SGS_IRQ_MASK_OFS = 5'h10;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int SGS_CFG_RANGE_LSB = 0;
    localparam int SGS_CFG_STEP_ACK_BIT = 3;
    localparam int SGS_CFG_CODE_ACK_BIT = 4;
    localparam int SGS_CFG_PWR_SYNC_BIT = 5;
    localparam logic [5:0] SGS_CFG_RESET = 6'h07;
    localparam logic [15:0] SGS_TIMEOUT_RESET = 16'h1388;
    localparam int SGS_ST_POS_LSB = 0;
    localparam int SGS_ST_PRE_LSB = 3;
    localparam int SGS_ST_GROUP_LSB = 6;
    localparam int SGS_ST_BUSY_BIT = 9;
    localparam int SGS_ST_ALARM_LSB = 10;

    // Interrupt bits: 0 position applied, 1 step alarm, 2 code alarm,
    // 3 range alarm, 4 power-up alarm, 5 group changed.
    localparam int SGS_IRQ_BITS = 6;
    localparam int SGS_IRQ_POS = 0;
    localparam int SGS_IRQ_ALARM_LSB = 1;
    localparam int SGS_IRQ_GROUP = 5;
    localparam int SGS_AL_STEP = 0;
    localparam int SGS_AL_CODE = 1;
    localparam int SGS_AL_RANGE = 2;
    localparam int SGS_AL_PWR = 3;

    typedef enum logic [1:0] {SGS_SEL_IDLE, SGS_SEL_STEP, SGS_SEL_CODE} sgs_sel_state_t;
endpackage : sgs_pkg

// file: src/sgs_grp_if.sv
`timescale 1ns/100ps
interface sgs_grp_if;
    logic [4:0] req;
    logic block;
    logic [2:0] active;
    logic changed;
    modport ctl (input req, input block, output active, output changed);
    modport usr (output req, output block, input active, input changed);
endinterface : sgs_grp_if

// file: src/sgs_group_sel.sv
`timescale 1ns/100ps
module sgs_group_sel (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Group requests and result
    sgs_grp_if.ctl grp
);
    import sgs_pkg::*;

    logic [2:0] group_reg;
    logic [2:0] group_next;
    logic changed_reg;

    // Highest requested group wins; group 1 has no request line.
    always_comb
    begin
        group_next = SGS_GROUP_DEFAULT;
        for (int i = 0; i < SGS_GROUPS - 1; i++)
        begin
            if (grp.req[i])
            begin
                group_next = 3'(i + 2);
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            group_reg <= SGS_GROUP_DEFAULT;
            changed_reg <= 1'b0;
        end
        else
        begin
            changed_reg <= 1'b0;
            if (!grp.block && group_next != group_reg)
            begin
                group_reg <= group_next;
                changed_reg <= 1'b1;
            end
        end
    end

    assign grp.active = group_reg;
    assign grp.changed = changed_reg;
endmodule : sgs_group_sel

// file: verif/sgs_nv_model.sv
`timescale 1ns/100ps
// ********
// Non-volatile position store seen from the control block.
// ********
module sgs_nv_model #(
    parameter logic [2:0] INIT = 3'h0
) (
    // Clock
    input wire logic core_clk,
    // Store port
    input wire logic nv_write,
    input wire logic [2:0] nv_position_out,
    output logic [2:0] nv_position_in
);
    logic [2:0] store_reg = INIT;

    // The store ignores reset so that a value survives power loss.
    always_ff @(posedge core_clk)
    begin
        if (nv_write)
            store_reg <= nv_position_out;
    end

    assign nv_position_in = store_reg;
endmodule : sgs_nv_model

// file: verif/sgs_ctrl_asserts.sv
`timescale 1ns/100ps
// ********
// Port checker for the selector and group control.
// ********
module sgs_ctrl_asserts #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register bus
    input wire logic read,
    input wire logic waitrequest,
    // Setting groups
    input wire logic [4:0] group_activate,
    input wire logic group_change_block,
    input wire logic [2:0] active_group,
    // Selector
    input wire logic [2:0] selector_position,
    input wire logic step_alarm,
    input wire logic range_alarm,
    input wire logic [2:0] nv_position_out,
    input wire logic nv_write
);
    import sgs_pkg::*;
    localparam int AL_MIN = (SGS_ALARM_TICKS - 1) * TICK_CYCLES;
    localparam int AL_MAX = (SGS_ALARM_TICKS + 1) * TICK_CYCLES;
    int unsigned al_cnt;

    // Counts the cycles for which the range alarm has been high.
    always_ff @(posedge core_clk)
    begin
        if (rst || !range_alarm)
            al_cnt <= 0;
        else
            al_cnt <= al_cnt + 1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_BUS_WAIT: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
        else $error("read not answered after one wait cycle");
    AST_GROUP_ONE: assert property (active_group >= 3'h1 && active_group <= 3'h6)
        else $error("active group outside one to six");
    AST_GROUP_FROZEN: assert property (group_change_block |=> $stable(active_group))
        else $error("group changed while blocked");
    AST_GROUP_TOP: assert property (!group_change_block && group_activate[4] |=> active_group == 3'h6)
        else $error("highest request did not win");
    AST_GROUP_DEFAULT: assert property (!group_change_block && group_activate == 5'h00 |=> active_group == SGS_GROUP_DEFAULT)
        else $error("group one not taken without requests");
    AST_NV_PULSE: assert property (nv_write |-> nv_position_out == selector_position ##1 !nv_write)
        else $error("store write wrong value or too long");
    AST_APPLY_ONLY: assert property ($changed(selector_position) && !$past(rst, 2) |-> nv_write)
        else $error("position changed without apply");
    AST_ALARM_SPAN: assert property ($fell(range_alarm) && !$past(rst) |-> al_cnt >= AL_MIN && al_cnt <= AL_MAX)
        else $error("range alarm length wrong");
    AST_STEP_DISCARD: assert property ($rose(step_alarm) |-> $stable(selector_position) && !nv_write)
        else $error("position applied with step alarm");
    AST_RANGE_KEEP: assert property ($rose(range_alarm) |-> $stable(selector_position) && !nv_write)
        else $error("position applied with range alarm");

    COV_APPLY: cover property (nv_write);
    COV_STEP_ALARM: cover property ($rose(step_alarm));
    COV_RANGE_END: cover property ($fell(range_alarm));
    COV_FROZEN: cover property (group_change_block && group_activate != 5'h00);
endmodule : sgs_ctrl_asserts

bind sgs_ctrl sgs_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_asserts (
    .core_clk(core_clk),
    .rst(rst),
    .read(read),
    .waitrequest(waitrequest),
    .group_activate(group_activate),
    .group_change_block(group_change_block),
    .active_group(active_group),
    .selector_position(selector_position),
    .step_alarm(step_alarm),
    .range_alarm(range_alarm),
    .nv_position_out(nv_position_out),
    .nv_write(nv_write)
);

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import sgs_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic irq;
    logic [4:0] group_activate = 5'h00;
    logic group_change_block = 1'b0;
    logic [2:0] active_group;
    logic step_advance = 1'b0;
    logic step_ack = 1'b0;
    logic [2:0] code = 3'h0;
    logic code_ack = 1'b0;
    logic [2:0] selector_position;
    logic step_alarm, code_alarm, range_alarm, power_alarm;
    logic [2:0] nv_position_in;
    logic [2:0] nv_position_out;
    logic nv_write;
    logic [31:0] rd;
    int n_fail = 0;
    int comparisons = 0;
    logic [4:0] g_req [7] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h0f, 5'h10, 5'h1f};
    logic [2:0] g_exp [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6};

    always #10 core_clk = ~core_clk;

    sgs_ctrl #(.TICK_CYCLES(10)) dut (
        .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .group_activate(group_activate), .group_change_block(group_change_block),
        .active_group(active_group), .step_advance(step_advance), .step_ack(step_ack),
        .position_code_bit0(code[0]), .position_code_bit1(code[1]),
        .position_code_bit2(code[2]), .code_ack(code_ack),
        .selector_position(selector_position), .step_alarm(step_alarm),
        .code_alarm(code_alarm), .range_alarm(range_alarm), .power_alarm(power_alarm),
        .nv_position_in(nv_position_in), .nv_position_out(nv_position_out),
        .nv_write(nv_write));

    sgs_nv_model #(.INIT(3'h3)) u_nv (.core_clk(core_clk), .nv_write(nv_write),
        .nv_position_out(nv_position_out), .nv_position_in(nv_position_in));

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One Avalon access; the thread rests mid-cycle between calls.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        writedata <= wd;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        check("bus wait", 32'(waitrequest), 32'h0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(negedge core_clk);
    endtask : bus

    task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, rd & m, exp);
    endtask : rchk

    task automatic grp(input logic [4:0] v, input logic blk);
        @(posedge core_clk);
        group_activate <= v;
        group_change_block <= blk;
        repeat (3) @(negedge core_clk);
    endtask : grp

    task automatic setcode(input logic [2:0] v);
        @(posedge core_clk);
        code <= v;
        repeat (3) @(negedge core_clk);
    endtask : setcode

    task automatic pulse(input int k);
        @(posedge core_clk);
        if (k == 0)
            step_advance <= 1'b1;
        else if (k == 1)
            step_ack <= 1'b1;
        else
            code_ack <= 1'b1;
        repeat (3) @(posedge core_clk);
        step_advance <= 1'b0;
        step_ack <= 1'b0;
        code_ack <= 1'b0;
        repeat (3) @(negedge core_clk);
    endtask : pulse

    task automatic wait_pos(input logic [2:0] exp, input int lim);
        int n;
        n = 0;
        while (selector_position !== exp && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        check("position", 32'(selector_position), 32'(exp));
    endtask : wait_pos

    initial
    begin
        repeat (60000) @(posedge core_clk);
        n_fail++;
        $display("watchdog expired");
        test_done();
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(negedge core_clk);
        check("restored position", 32'(selector_position), 32'h3);
        rchk("cfg", SGS_CFG_OFS, 32'hffffffff, 32'h7);
        rchk("timeout", SGS_TIMEOUT_OFS, 32'hffffffff, 32'h1388);
        rchk("unmapped", 5'h14, 32'hffffffff, 32'h0);
        bus(1'b1, SGS_STATUS_OFS, 32'hffffffff);
        rchk("status", SGS_STATUS_OFS, 32'h1c7, 32'h43);
        $display("test registers done");
        for (int i = 0; i < 7; i++)
        begin
            grp(g_req[i], 1'b0);
            check("group", 32'(active_group), 32'(g_exp[i]));
        end
        grp(5'h00, 1'b1);
        check("blocked group", 32'(active_group), 32'h6);
        grp(5'h00, 1'b0);
        check("default group", 32'(active_group), 32'h1);
        bus(1'b1, SGS_IRQ_MASK_OFS, 32'h20);
        bus(1'b1, SGS_IRQ_STAT_OFS, 32'h3f);
        check("irq idle", 32'(irq), 32'h0);
        grp(5'h01, 1'b0);
        check("irq raised", 32'(irq), 32'h1);
        rchk("irq status", SGS_IRQ_STAT_OFS, 32'h20, 32'h20);
        bus(1'b1, SGS_IRQ_STAT_OFS, 32'h20);
        check("irq cleared", 32'(irq), 32'h0);
        bus(1'b1, SGS_IRQ_MASK_OFS, 32'h0);
        grp(5'h00, 1'b0);
        check("irq masked", 32'(irq), 32'h0);
        $display("test groups done");
        bus(1'b1, SGS_TIMEOUT_OFS, 32'h2);
        pulse(0);
        check("not yet applied", 32'(selector_position), 32'h3);
        pulse(0);
        wait_pos(3'h5, 200);
        @(negedge core_clk);
        check("stored", 32'(nv_position_in), 32'h5);
        bus(1'b1, SGS_CFG_OFS, 32'h05);
        pulse(0);
        wait_pos(3'h1, 200);
        setcode(3'h2);
        wait_pos(3'h2, 200);
        setcode(3'h6);
        check("range alarm", 32'(range_alarm), 32'h1);
        setcode(3'h0);
        repeat (60) @(negedge core_clk);
        check("rest code", 32'(selector_position), 32'h2);
        setcode(3'h5);
        wait_pos(3'h5, 200);
        setcode(3'h0);
        pulse(0);
        setcode(3'h3);
        setcode(3'h0);
        wait_pos(3'h1, 200);
        $display("test selector time-out done");
        bus(1'b1, SGS_CFG_OFS, 32'h0d);
        pulse(0);
        pulse(1);
        wait_pos(3'h2, 10);
        pulse(0);
        repeat (60) @(negedge core_clk);
        check("step alarm", 32'(step_alarm), 32'h1);
        check("discarded", 32'(selector_position), 32'h2);
        bus(1'b1, SGS_CFG_OFS, 32'h15);
        setcode(3'h4);
        check("waits for ack", 32'(selector_position), 32'h2);
        pulse(2);
        wait_pos(3'h4, 10);
        setcode(3'h3);
        repeat (60) @(negedge core_clk);
        check("code alarm", 32'(code_alarm), 32'h1);
        check("code discarded", 32'(selector_position), 32'h4);
        $display("test acknowledge done");
        for (int n = 0; n < 40000 && range_alarm !== 1'b0; n++)
            @(negedge core_clk);
        check("range alarm end", 32'(range_alarm), 32'h0);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(negedge core_clk);
        check("power-up restore", 32'(selector_position), 32'h4);
        check("power alarm", 32'(power_alarm), 32'h0);
        $display("test power-up done");
        test_done();
    end
endmodule : tb_top
